//--- rtl/iss_map.svh
// Register offsets, field positions and reset values of the image setting sequencer.
// Assumes a 32-bit APB slave with byte addresses; each register is one aligned word.
`ifndef ISS_MAP_SVH
`define ISS_MAP_SVH
`define ISS_A_CTRL      12'h000
`define ISS_A_STATUS    12'h004
`define ISS_A_FSEL      12'h008
`define ISS_A_FEN       12'h00c
`define ISS_A_START     12'h010
`define ISS_A_ACTIVE    12'h014
`define ISS_A_SSEL      12'h018
`define ISS_A_CMD       12'h01c
`define ISS_A_PSEL      12'h020
`define ISS_A_BRANCH    12'h024
`define ISS_A_LIVE0     12'h040
`define ISS_B_RUN       0
`define ISS_B_SETUP     1
`define ISS_B_SAVE      0
`define ISS_B_LOAD      1
`define ISS_B_ERASE     2
`define ISS_B_ORIGIN    0
`define ISS_B_COND      4
`define ISS_B_TARGET    8
`define ISS_NFEAT       5
`define ISS_RST_FEN     5'h00
`endif

//--- rtl/iss_pkg.sv
// Types shared by the image setting sequencer modules.
// Assumes the map header is included by each user for the constants.
package iss_pkg;
	typedef enum logic [2:0] {
		FEAT_GAIN   = 3'h0,
		FEAT_WIDTH  = 3'h1,
		FEAT_HEIGHT = 3'h2,
		FEAT_HORIZ  = 3'h3,
		FEAT_VERT   = 3'h4
	} iss_feat_e;
	typedef enum logic [2:0] {
		COND_RISE = 3'h0,
		COND_FALL = 3'h1,
		COND_ANY  = 3'h2,
		COND_HIGH = 3'h3,
		COND_LOW  = 3'h4
	} iss_cond_e;
	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_SAVE  = 2'h1,
		ST_LOAD  = 2'h2,
		ST_ERASE = 2'h3
	} iss_cmd_e;
	typedef struct packed {
		logic       origin_on;
		iss_cond_e  cond;
	} iss_branch_s;
endpackage : iss_pkg

//--- rtl/iss_trig.sv
// Activation condition check of one branch against the frame-start event line.
// Assumes the event line and its previous sample are synchronous to the clock.
module iss_trig
	import iss_pkg::*;
(
	input  wire logic        evt,
	input  wire logic        evt_prev,
	input  wire iss_branch_s br,
	output logic             fire
);
	always_comb begin
		fire = 1'b0;
		if (br.origin_on) begin
			case (br.cond)
				COND_RISE: fire = evt & ~evt_prev;
				COND_FALL: fire = ~evt & evt_prev;
				COND_ANY:  fire = evt ^ evt_prev;
				COND_HIGH: fire = evt;
				COND_LOW:  fire = ~evt;
				default:   fire = 1'b0;
			endcase
		end
	end
endmodule : iss_trig

//--- rtl/iss_store.sv
// Storage of set contents: one word per setting per set, written one word per cycle.
// Assumes the controller walks the words itself; reads are combinational.
module iss_store #(
	parameter int NSET = 8,
	parameter int DW   = 16,
	parameter int NF   = 5
) (
	input  wire logic                      clk,
	input  wire logic                      we,
	input  wire logic [$clog2(NSET)-1:0]   wset,
	input  wire logic [$clog2(NF)-1:0]     wfeat,
	input  wire logic [DW-1:0]             wdata,
	input  wire logic [$clog2(NSET)-1:0]   rset,
	input  wire logic [$clog2(NF)-1:0]     rfeat,
	output logic      [DW-1:0]             rdata
);
	// No reset on the array: validity bits in the controller guard stale contents only on command register loads.
	logic [DW-1:0] mem [NSET*NF];
	always_ff @(posedge clk) begin
		if (we) begin
			mem[int'(wset)*NF+int'(wfeat)] <= wdata;
		end
	end
	assign rdata = mem[int'(rset)*NF+int'(rfeat)];
endmodule : iss_store

//--- rtl/iss_seq.sv
// Image setting sequencer with APB register access and frame-start driven stepping.
// Assumes EXPOSURE_BEGIN is a synchronous level from the acquisition logic on MCLK.
`include "iss_map.svh"
module iss_seq
	import iss_pkg::*;
#(
	parameter int NSET = 8,
	parameter int NPATH = 2,
	parameter int DW = 16
) (
	input  wire logic        MCLK,
	input  wire logic        RESETN,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        EXPOSURE_BEGIN,
	output logic [5*DW-1:0]  LIVE_SETTINGS,
	output logic             SETTINGS_LOCKED
);
	localparam int SW = $clog2(NSET);
	localparam int PW = $clog2(NPATH);
	localparam int FW = 3;
	localparam int NF = `ISS_NFEAT;

	typedef struct packed {
		logic                 run;
		logic                 setup;
		logic                 cfg_ok;
		iss_feat_e            fsel;
		logic [NF-1:0]        fen;
		logic [SW-1:0]        start;
		logic [SW-1:0]        active;
		logic [SW-1:0]        ssel;
		logic [PW-1:0]        psel;
		logic [NSET-1:0]      valid;
		iss_cmd_e             cmd;
		logic [FW-1:0]        widx;
		logic [SW-1:0]        cset;
		logic                 evt_prev;
		logic [NF-1:0][DW-1:0] live;
		logic [NSET*NPATH-1:0][3:0] brc;
		logic [NSET*NPATH-1:0][SW-1:0] btgt;
		logic [31:0]          rdata;
		logic                 ready;
		logic                 err;
	} iss_state_s;

	iss_state_s st_ff, nxt_st;
	logic [DW-1:0] st_rdata;
	logic          st_we;
	logic [DW-1:0] st_wdata;
	logic [NPATH-1:0] fire;

	function automatic int bidx(input logic [SW-1:0] s, input logic [PW-1:0] p);
		return int'(s) * NPATH + int'(p);
	endfunction : bidx

	iss_store #(.NSET(NSET), .DW(DW), .NF(NF)) u_store (
		.clk   (MCLK),
		.we    (st_we),
		.wset  (st_ff.cset),
		.wfeat (st_ff.widx),
		.wdata (st_wdata),
		.rset  (st_ff.cset),
		.rfeat (st_ff.widx),
		.rdata (st_rdata)
	);

	for (genvar g = 0; g < NPATH; g++) begin : g_path
		iss_trig u_trig (
			.evt      (EXPOSURE_BEGIN),
			.evt_prev (st_ff.evt_prev),
			.br       (iss_branch_s'(st_ff.brc[bidx(st_ff.active, PW'(g))])),
			.fire     (fire[g])
		);
	end

	wire acc = PSEL & PENABLE & ~st_ff.ready;
	wire wr  = acc & PWRITE;
	wire [31:0] wd = PWDATA;
	wire busy = (st_ff.cmd != ST_IDLE);

	always_comb begin
		int b;
		int k;
		logic ok;
		b = bidx(st_ff.ssel, st_ff.psel);
		k = 0;
		ok = 1'b0;
		nxt_st = st_ff;
		nxt_st.ready = acc;
		nxt_st.err = 1'b0;
		nxt_st.rdata = '0;
		nxt_st.evt_prev = EXPOSURE_BEGIN;
		st_we = 1'b0;
		st_wdata = st_ff.fen[st_ff.widx] ? st_ff.live[st_ff.widx] : '0;
		// Command walk: one setting word per cycle.
		case (st_ff.cmd)
			ST_SAVE: begin
				st_we = 1'b1;
				if (int'(st_ff.widx) == NF-1) begin
					nxt_st.cmd = ST_IDLE;
					nxt_st.valid[st_ff.cset] = 1'b1;
				end
				nxt_st.widx = st_ff.widx + 1'b1;
			end
			ST_LOAD: begin
				if (st_ff.fen[st_ff.widx]) begin
					nxt_st.live[st_ff.widx] = st_rdata;
				end
				if (int'(st_ff.widx) == NF-1) begin
					nxt_st.cmd = ST_IDLE;
				end
				nxt_st.widx = st_ff.widx + 1'b1;
			end
			ST_ERASE: begin
				nxt_st.valid = '0;
				nxt_st.cmd = ST_IDLE;
			end
			default: nxt_st.widx = '0;
		endcase
		// Stepping between sets; the lowest-numbered firing path wins.
		if (st_ff.run && !busy) begin
			for (int p = NPATH-1; p >= 0; p--) begin
				if (fire[p]) begin
					nxt_st.active = st_ff.btgt[bidx(st_ff.active, PW'(p))];
					ok = 1'b1;
				end
			end
			if (ok) begin
				nxt_st.cset = nxt_st.active;
				nxt_st.cmd = ST_LOAD;
				nxt_st.widx = '0;
			end
		end
		if (acc) begin
			if (PADDR == `ISS_A_CTRL) begin
				nxt_st.rdata = {30'h0, st_ff.setup, st_ff.run};
				if (wr) begin
					nxt_st.run = wd[`ISS_B_RUN];
					nxt_st.setup = wd[`ISS_B_SETUP];
					if (wd[`ISS_B_RUN] && !st_ff.run && !busy) begin
						nxt_st.active = st_ff.start;
						nxt_st.cset = st_ff.start;
						nxt_st.cmd = ST_LOAD;
						nxt_st.widx = '0;
					end
					if (!wd[`ISS_B_SETUP] && st_ff.setup) begin
						ok = st_ff.valid[st_ff.start];
						for (int i = 0; i < NSET*NPATH; i++) begin
							if (st_ff.valid[i/NPATH] && st_ff.brc[i][3]
							    && !st_ff.valid[st_ff.btgt[i]]) begin
								ok = 1'b0;
							end
						end
						nxt_st.cfg_ok = ok;
					end
				end
			end else if (PADDR == `ISS_A_STATUS) begin
				nxt_st.rdata = {30'h0, st_ff.valid[st_ff.ssel], st_ff.cfg_ok};
			end else if (PADDR == `ISS_A_FSEL) begin
				nxt_st.rdata = {29'h0, st_ff.fsel};
				if (wr && int'(wd[2:0]) < NF) nxt_st.fsel = iss_feat_e'(wd[2:0]);
			end else if (PADDR == `ISS_A_FEN) begin
				nxt_st.rdata = {31'h0, st_ff.fen[st_ff.fsel]};
				if (wr && !st_ff.run) nxt_st.fen[st_ff.fsel] = wd[0];
			end else if (PADDR == `ISS_A_START) begin
				nxt_st.rdata = 32'(st_ff.start);
				if (wr) nxt_st.start = wd[SW-1:0];
			end else if (PADDR == `ISS_A_ACTIVE) begin
				nxt_st.rdata = 32'(st_ff.active);
			end else if (PADDR == `ISS_A_SSEL) begin
				nxt_st.rdata = 32'(st_ff.ssel);
				if (wr) nxt_st.ssel = wd[SW-1:0];
			end else if (PADDR == `ISS_A_CMD) begin
				nxt_st.rdata = '0;
				if (wr && !busy) begin
					nxt_st.cset = st_ff.ssel;
					nxt_st.widx = '0;
					if (wd[`ISS_B_ERASE]) nxt_st.cmd = ST_ERASE;
					else if (wd[`ISS_B_SAVE]) nxt_st.cmd = ST_SAVE;
					else if (wd[`ISS_B_LOAD] && !st_ff.run
					         && st_ff.valid[st_ff.ssel]) nxt_st.cmd = ST_LOAD;
				end
			end else if (PADDR == `ISS_A_PSEL) begin
				nxt_st.rdata = 32'(st_ff.psel);
				if (wr) nxt_st.psel = wd[PW-1:0];
			end else if (PADDR == `ISS_A_BRANCH) begin
				// Fields read back where they are written, so a read word can be written back.
				nxt_st.rdata[`ISS_B_ORIGIN] = st_ff.brc[b][3];
				nxt_st.rdata[`ISS_B_COND +: 3] = st_ff.brc[b][2:0];
				nxt_st.rdata[`ISS_B_TARGET +: SW] = st_ff.btgt[b];
				if (wr) begin
					nxt_st.brc[b] = {wd[`ISS_B_ORIGIN], wd[`ISS_B_COND+2:`ISS_B_COND]};
					nxt_st.btgt[b] = wd[`ISS_B_TARGET+SW-1:`ISS_B_TARGET];
				end
			end else if (PADDR >= `ISS_A_LIVE0 && PADDR < `ISS_A_LIVE0 + 12'(4*NF)) begin
				k = int'(PADDR[5:2]);
				nxt_st.rdata = 32'(st_ff.live[k]);
				// Locked settings hold the sequencer's values; writes are dropped.
				if (wr && !(st_ff.run && st_ff.fen[k])) begin
					nxt_st.live[k] = wd[DW-1:0];
				end
			end else begin
				nxt_st.err = 1'b1;
			end
		end
	end

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign PRDATA = st_ff.rdata;
	assign PREADY = st_ff.ready;
	assign PSLVERR = st_ff.err;
	assign LIVE_SETTINGS = st_ff.live;
	assign SETTINGS_LOCKED = st_ff.run;

	property p_active_ro;
		@(posedge MCLK) disable iff (!RESETN)
		(wr && PADDR == `ISS_A_ACTIVE && !st_ff.run) |=> $stable(st_ff.active);
	endproperty
	a_active_ro: assert property (p_active_ro) else $error("active index changed by write");
	property p_start;
		@(posedge MCLK) disable iff (!RESETN)
		(wr && PADDR == `ISS_A_CTRL && wd[`ISS_B_RUN] && !st_ff.run && !busy)
		|=> (st_ff.active == $past(st_ff.start)) && st_ff.cmd == ST_LOAD;
	endproperty
	a_start: assert property (p_start) else $error("first set not applied");
	property p_save_len;
		@(posedge MCLK) disable iff (!RESETN)
		$rose(st_ff.cmd == ST_SAVE) |-> (st_ff.cmd == ST_SAVE)[*5] ##1 st_ff.cmd == ST_IDLE;
	endproperty
	a_save_len: assert property (p_save_len) else $error("save walk length wrong");
	property p_save_valid;
		@(posedge MCLK) disable iff (!RESETN)
		(st_ff.cmd == ST_SAVE && int'(st_ff.widx) == NF-1) |=> st_ff.valid[$past(st_ff.cset)];
	endproperty
	a_save_valid: assert property (p_save_valid) else $error("saved set not valid");
	property p_erase;
		@(posedge MCLK) disable iff (!RESETN)
		st_ff.cmd == ST_ERASE |=> st_ff.valid == '0;
	endproperty
	a_erase: assert property (p_erase) else $error("erase left valid set");
	property p_lock;
		@(posedge MCLK) disable iff (!RESETN)
		(wr && PADDR == `ISS_A_LIVE0 && st_ff.run && st_ff.fen[0] && !busy)
		|=> $stable(st_ff.live[0]);
	endproperty
	a_lock: assert property (p_lock) else $error("locked setting written");
	property p_stop_keep;
		@(posedge MCLK) disable iff (!RESETN)
		($fell(st_ff.run) && !busy) |-> $stable(st_ff.live);
	endproperty
	a_stop_keep: assert property (p_stop_keep) else $error("stop changed live values");
	property p_cmd_read;
		@(posedge MCLK) disable iff (!RESETN)
		(acc && !PWRITE && PADDR == `ISS_A_CMD) |=> PRDATA == 32'h0 && PREADY;
	endproperty
	a_cmd_read: assert property (p_cmd_read) else $error("command read not zero");
	property p_step;
		@(posedge MCLK) disable iff (!RESETN)
		(st_ff.run && !busy && !acc && fire[0])
		|=> st_ff.active == $past(st_ff.btgt[bidx(st_ff.active, '0)]);
	endproperty
	a_step: assert property (p_step) else $error("path did not step");
	property p_load_len;
		@(posedge MCLK) disable iff (!RESETN)
		$rose(st_ff.cmd == ST_LOAD) |-> (st_ff.cmd == ST_LOAD)[*5] ##1 st_ff.cmd == ST_IDLE;
	endproperty
	a_load_len: assert property (p_load_len) else $error("load walk length wrong");
	property p_fen_lock;
		@(posedge MCLK) disable iff (!RESETN)
		(wr && PADDR == `ISS_A_FEN && st_ff.run) |=> $stable(st_ff.fen);
	endproperty
	a_fen_lock: assert property (p_fen_lock) else $error("enable changed while running");
	property p_fsel_wr;
		@(posedge MCLK) disable iff (!RESETN)
		(wr && PADDR == `ISS_A_FSEL && int'(wd[2:0]) < NF) |=> st_ff.fsel == $past(wd[2:0]);
	endproperty
	a_fsel_wr: assert property (p_fsel_wr) else $error("setting choice not taken");
	property p_start_wr;
		@(posedge MCLK) disable iff (!RESETN)
		(wr && PADDR == `ISS_A_START) |=> st_ff.start == $past(wd[SW-1:0]);
	endproperty
	a_start_wr: assert property (p_start_wr) else $error("first set index not taken");
	property p_ssel_wr;
		@(posedge MCLK) disable iff (!RESETN)
		(wr && PADDR == `ISS_A_SSEL) |=> st_ff.ssel == $past(wd[SW-1:0]);
	endproperty
	a_ssel_wr: assert property (p_ssel_wr) else $error("edited set not taken");
	property p_psel_wr;
		@(posedge MCLK) disable iff (!RESETN)
		(wr && PADDR == `ISS_A_PSEL) |=> st_ff.psel == $past(wd[PW-1:0]);
	endproperty
	a_psel_wr: assert property (p_psel_wr) else $error("edited branch not taken");
endmodule : iss_seq

//--- sim/iss_seq_tb.sv
// Self-checking bench of the image setting sequencer, with an APB master and a reference model.
// Assumes iss_seq alone on one clock, with the frame-start line driven by the bench.
`include "iss_map.svh"
module iss_seq_tb
	import iss_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk = 1'b0;
	logic        resetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic        evt = 1'b0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [79:0] live;
	logic        locked;
	logic [31:0] rd;
	logic        err;
	logic [31:0] rng = 32'hc0c53ff9;
	logic [15:0] m_live [5];
	logic [15:0] m_set [8][5];
	int          n_errors = 0;
	int          n_compared = 0;
	int          cyc = 0;

	always #4 mclk = ~mclk;

	iss_seq #(.NSET(8), .NPATH(2), .DW(16)) iss_seq_inst (
		.MCLK           (mclk),
		.RESETN         (resetn),
		.PSEL           (psel),
		.PENABLE        (penable),
		.PWRITE         (pwrite),
		.PADDR          (paddr),
		.PWDATA         (pwdata),
		.PRDATA         (prdata),
		.PREADY         (pready),
		.PSLVERR        (pslverr),
		.EXPOSURE_BEGIN (evt),
		.LIVE_SETTINGS  (live),
		.SETTINGS_LOCKED(locked)
	);

	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : stop_test

	// A hung handshake ends the run here rather than stalling forever.
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			$display("wrong value timeout expected 0 seen 1");
			stop_test();
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	function automatic logic [79:0] pack();
		return {m_live[4], m_live[3], m_live[2], m_live[1], m_live[0]};
	endfunction : pack

	task automatic chk(input string what, input logic [79:0] exp, input logic [79:0] got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Request is held until pready is sampled high; an idle edge follows so strobes never
	// get two assignments in one time step.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(what, 80'(exp), 80'(rd));
	endtask : rdc

	// Save and load take five cycles to walk, so seven idle cycles keep them apart.
	task automatic cmd(input int b);
		wr(`ISS_A_CMD, 32'h1 << b);
		repeat (7) @(posedge mclk);
	endtask : cmd

	task automatic set_live(input int f);
		rng = xs(rng);
		wr(`ISS_A_LIVE0 + 12'(4 * f), 32'(rng[15:0]));
		m_live[f] = rng[15:0];
	endtask : set_live

	initial begin
		logic lvl;
		for (int f = 0; f < 5; f++) m_live[f] = 16'h0000;
		repeat (20) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		chk("live", 80'h0, live);
		rdc("ctrl", `ISS_A_CTRL, 32'h0);
		rdc("status", `ISS_A_STATUS, 32'h0);
		rdc("active", `ISS_A_ACTIVE, 32'h0);
		$display("test reset done");
		for (int f = 0; f < 5; f++) begin
			wr(`ISS_A_FSEL, 32'(f));
			rdc("choice", `ISS_A_FSEL, 32'(f));
			wr(`ISS_A_FEN, 32'h1);
			rdc("enable", `ISS_A_FEN, 32'h1);
		end
		wr(`ISS_A_START, 32'h3);
		rdc("first", `ISS_A_START, 32'h3);
		wr(`ISS_A_ACTIVE, 32'h5);
		rdc("active", `ISS_A_ACTIVE, 32'h0);
		wr(`ISS_A_SSEL, 32'h6);
		rdc("edited set", `ISS_A_SSEL, 32'h6);
		wr(`ISS_A_PSEL, 32'h1);
		rdc("edited branch", `ISS_A_PSEL, 32'h1);
		for (int c = 0; c < 5; c++) begin
			wr(`ISS_A_BRANCH, 32'((c << 8) | (c << 4) | (c & 1)));
			rdc("branch", `ISS_A_BRANCH, 32'((c << 8) | (c << 4) | (c & 1)));
		end
		rdc("cmd", `ISS_A_CMD, 32'h0);
		apb(1'b0, 12'h0fc, 32'h0);
		chk("slverr", 80'h1, 80'(err));
		$display("test registers done");
		for (int s = 0; s < 2; s++) begin
			for (int f = 0; f < 5; f++) set_live(f);
			chk("live", pack(), live);
			wr(`ISS_A_SSEL, 32'(s));
			cmd(`ISS_B_SAVE);
			for (int f = 0; f < 5; f++) m_set[s][f] = m_live[f];
			apb(1'b0, `ISS_A_STATUS, 32'h0);
			chk("set valid", 80'h1, 80'(rd[1]));
		end
		for (int f = 0; f < 5; f++) set_live(f);
		wr(`ISS_A_SSEL, 32'h0);
		cmd(`ISS_B_LOAD);
		for (int f = 0; f < 5; f++) m_live[f] = m_set[0][f];
		chk("loaded live", pack(), live);
		$display("test save load done");
		wr(`ISS_A_SSEL, 32'h1);
		wr(`ISS_A_PSEL, 32'h0);
		wr(`ISS_A_BRANCH, 32'h0);
		wr(`ISS_A_PSEL, 32'h1);
		wr(`ISS_A_BRANCH, 32'h0);
		wr(`ISS_A_SSEL, 32'h0);
		wr(`ISS_A_BRANCH, 32'h0);
		wr(`ISS_A_PSEL, 32'h0);
		wr(`ISS_A_BRANCH, 32'h101);
		wr(`ISS_A_START, 32'h5);
		wr(`ISS_A_CTRL, 32'h2);
		wr(`ISS_A_CTRL, 32'h0);
		apb(1'b0, `ISS_A_STATUS, 32'h0);
		chk("setup ok", 80'h0, 80'(rd[0]));
		wr(`ISS_A_START, 32'h0);
		wr(`ISS_A_CTRL, 32'h2);
		wr(`ISS_A_CTRL, 32'h0);
		apb(1'b0, `ISS_A_STATUS, 32'h0);
		chk("setup ok", 80'h1, 80'(rd[0]));
		$display("test setup check done");
		for (int c = 0; c < 5; c++) begin
			lvl = (3'(c) == COND_FALL) || (3'(c) == COND_LOW);
			evt <= lvl;
			wr(`ISS_A_BRANCH, 32'(32'h101 | (c << 4)));
			wr(`ISS_A_CTRL, 32'h1);
			repeat (8) @(posedge mclk);
			for (int f = 0; f < 5; f++) m_live[f] = m_set[0][f];
			chk("run live", pack(), live);
			chk("locked", 80'h1, 80'(locked));
			wr(`ISS_A_LIVE0, 32'h1234);
			chk("locked live", pack(), live);
			wr(`ISS_A_FEN, 32'h0);
			rdc("locked enable", `ISS_A_FEN, 32'h1);
			rdc("active", `ISS_A_ACTIVE, 32'h0);
			evt <= ~lvl;
			repeat (10) @(posedge mclk);
			for (int f = 0; f < 5; f++) m_live[f] = m_set[1][f];
			chk("stepped live", pack(), live);
			rdc("active", `ISS_A_ACTIVE, 32'h1);
			evt <= lvl;
			repeat (4) @(posedge mclk);
			evt <= ~lvl;
			repeat (10) @(posedge mclk);
			rdc("active", `ISS_A_ACTIVE, 32'h1);
			wr(`ISS_A_CTRL, 32'h0);
			chk("unlocked", 80'h0, 80'(locked));
			chk("kept live", pack(), live);
			set_live(0);
			chk("free live", pack(), live);
			$display("test condition %0d done", c);
		end
		cmd(`ISS_B_ERASE);
		apb(1'b0, `ISS_A_STATUS, 32'h0);
		chk("erased valid", 80'h0, 80'(rd[1]));
		cmd(`ISS_B_LOAD);
		chk("no load", pack(), live);
		$display("test erase done");
		stop_test();
	end
endmodule : iss_seq_tb
